// File: core/dyn_thresh_pkg.sv
package dyn_thresh_pkg;

    // register word indices; byte address is four times the index
    localparam logic [7:0] REG_CTRL1_IDX = 8'h36;
    localparam logic [7:0] REG_INTERVAL_IDX = 8'h37;
    localparam logic [7:0] REG_OPPOINT_R2_IDX = 8'h38;
    localparam logic [7:0] REG_STATUS_IDX = 8'h39;

    // reset values
    localparam logic [7:0] INTERVAL_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] OPPOINT_RESET = 8'h00;

    // interval register field positions
    localparam int REMOTE1_CODE_LSB = 0;
    localparam int LOCAL_CODE_LSB = 3;
    localparam int REMOTE2_CODE_LSB = 6;
    localparam int CODE_W = 3;

    // companion register field positions
    localparam int REMOTE2_CODE_MSB_BIT = 0;
    localparam int CAPTURE_EN_BIT = 4;

    // status register field positions
    localparam int STATUS_DEC_LSB = 0;
    localparam int STATUS_INC_LSB = 3;

    // channel numbering
    localparam int CH_LOCAL = 0;
    localparam int CH_REMOTE1 = 1;
    localparam int CH_REMOTE2 = 2;
    localparam int NUM_CH = 3;

    // interval lengths in monitoring cycles
    localparam int CNT_W = 10;
    localparam logic [9:0] DEC_BASE_CYCLES = 10'h004;
    localparam logic [9:0] INC_BASE_CYCLES = 10'h010;
    localparam logic [9:0] MAX_CYCLES = 10'h200;
    localparam logic [2:0] INC_SAT_CODE = 3'h5;

    // timebase: one monitoring cycle lasts 125 ms, clock is 250 MHz
    localparam int MON_CYCLE_US = 125000;
    localparam int CLK_FREQ_MHZ = 250;
    localparam int MON_CYCLE_CLKS = MON_CYCLE_US * CLK_FREQ_MHZ;
    localparam int TICK_W = 25;

endpackage : dyn_thresh_pkg

// File: core/step_interval_timer.sv
`timescale 1ns/10ps
module step_interval_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // timebase and loop events
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic [dyn_thresh_pkg::CODE_W-1:0] code_i,
    // permissions
    output logic dec_ok_o,
    output logic inc_ok_o
);
    import dyn_thresh_pkg::*;

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic dec_ok_q;
    logic inc_ok_q;
    wire [CNT_W-1:0] dec_len;
    wire [CNT_W-1:0] inc_len;
    wire count_sat;

    assign dec_len = DEC_BASE_CYCLES << code_i;
    assign inc_len = (code_i >= INC_SAT_CODE) ? MAX_CYCLES : (INC_BASE_CYCLES << code_i);

    // counting stops at the longest interval, so the counter never wraps
    assign count_sat = (count_q >= MAX_CYCLES);

    always_comb begin
        count_d = count_q;
        if (restart_i) begin
            count_d = '0;
        end else if (tick_i && !count_sat) begin
            count_d = count_q + 10'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= '0;
            dec_ok_q <= 1'b0;
            inc_ok_q <= 1'b0;
        end else begin
            count_q <= count_d;
            dec_ok_q <= (count_d >= dec_len);
            inc_ok_q <= (count_d >= inc_len);
        end
    end

    assign dec_ok_o = dec_ok_q;
    assign inc_ok_o = inc_ok_q;

endmodule : step_interval_timer

// File: core/dyn_thresh_interval.sv
// Operation
// - low three bits pick the remote 1 channel's step interval.
// - middle three bits pick the local channel's step interval.
// - remote 2 code: low bits from top bits, msb from companion register.
// - decrease intervals are 4 to 512 monitoring cycles, doubling per code.
// - increase intervals start at 16 cycles, double per code, saturate at 512.
// - reset clears the interval register, giving shortest intervals everywhere.
// - with capture enabled, alarm assertion copies remote 2 temperature to operating point.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
module dyn_thresh_interval #(
    parameter int MON_CLKS = dyn_thresh_pkg::MON_CYCLE_CLKS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // threshold loop
    input wire logic [dyn_thresh_pkg::NUM_CH-1:0] step_done_i,
    output logic [dyn_thresh_pkg::NUM_CH-1:0] dec_allow_o,
    output logic [dyn_thresh_pkg::NUM_CH-1:0] inc_allow_o,
    output logic mon_tick_o,
    output logic [dyn_thresh_pkg::CODE_W-1:0] local_interval_code_o,
    output logic [dyn_thresh_pkg::CODE_W-1:0] remote1_interval_code_o,
    output logic [dyn_thresh_pkg::CODE_W-1:0] remote2_interval_code_o,
    // remote 2 operating point
    input wire logic thermal_alarm_pin_i,
    input wire logic [7:0] remote2_temp_i,
    output logic [7:0] remote2_oppoint_o
);
    import dyn_thresh_pkg::*;

    // register state
    logic [7:0] interval_q;
    logic [7:0] interval_d;
    logic remote2_code_msb_q;
    logic remote2_code_msb_d;
    logic remote2_oppoint_capture_en_q;
    logic remote2_oppoint_capture_en_d;
    logic [7:0] oppoint_q;
    logic [7:0] oppoint_d;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // timebase
    logic [TICK_W-1:0] tick_cnt_q;
    logic [TICK_W-1:0] tick_cnt_d;
    logic tick_q;

    // alarm synchroniser and edge detect
    logic alarm_meta_q;
    logic alarm_sync_q;
    logic alarm_prev_q;

    // bus decode
    wire bus_req;
    wire bus_write;
    wire lane0_write;
    wire [7:0] word_idx;
    wire hit_ctrl1;
    wire hit_interval;
    wire hit_oppoint;
    wire hit_status;
    wire [7:0] ctrl1_rd;
    wire [7:0] status_rd;

    // channel codes
    wire [CODE_W-1:0] local_code;
    wire [CODE_W-1:0] remote1_code;
    wire [CODE_W-1:0] remote2_code;
    wire [CODE_W-1:0] ch_code [NUM_CH];
    wire [NUM_CH-1:0] dec_ok;
    wire [NUM_CH-1:0] inc_ok;

    // alarm events
    wire alarm_rise;
    wire capture;

    // ack is registered, so every access takes exactly one wait state
    assign bus_req = cyc_i && stb_i && !ack_q;
    assign bus_write = bus_req && we_i;
    assign lane0_write = bus_write && sel_i[0];
    assign word_idx = adr_i[9:2];
    assign hit_ctrl1 = (word_idx == REG_CTRL1_IDX);
    assign hit_interval = (word_idx == REG_INTERVAL_IDX);
    assign hit_oppoint = (word_idx == REG_OPPOINT_R2_IDX);
    assign hit_status = (word_idx == REG_STATUS_IDX);

    assign remote1_code = interval_q[REMOTE1_CODE_LSB +: CODE_W];
    assign local_code = interval_q[LOCAL_CODE_LSB +: CODE_W];
    assign remote2_code = {remote2_code_msb_q, interval_q[REMOTE2_CODE_LSB +: 2]};

    assign ch_code[CH_LOCAL] = local_code;
    assign ch_code[CH_REMOTE1] = remote1_code;
    assign ch_code[CH_REMOTE2] = remote2_code;

    // readback layouts; unused bits read as zero
    assign ctrl1_rd = (8'h01 << REMOTE2_CODE_MSB_BIT) & {8{remote2_code_msb_q}}
                    | (8'h01 << CAPTURE_EN_BIT) & {8{remote2_oppoint_capture_en_q}};
    assign status_rd = {2'b00, inc_ok, dec_ok};

    assign alarm_rise = alarm_sync_q && !alarm_prev_q;
    assign capture = alarm_rise && remote2_oppoint_capture_en_q;

    // register writes
    always_comb begin
        interval_d = interval_q;
        remote2_code_msb_d = remote2_code_msb_q;
        remote2_oppoint_capture_en_d = remote2_oppoint_capture_en_q;
        oppoint_d = oppoint_q;
        if (lane0_write && hit_interval) begin
            interval_d = dat_i[7:0];
        end
        if (lane0_write && hit_ctrl1) begin
            remote2_code_msb_d = dat_i[REMOTE2_CODE_MSB_BIT];
            remote2_oppoint_capture_en_d = dat_i[CAPTURE_EN_BIT];
        end
        if (lane0_write && hit_oppoint) begin
            oppoint_d = dat_i[7:0];
        end
        if (capture) begin
            oppoint_d = remote2_temp_i;
        end
    end

    // read mux; unmapped words read as zero and still ack
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_interval) begin
            rdata_d = {24'h00_0000, interval_q};
        end else if (hit_ctrl1) begin
            rdata_d = {24'h00_0000, ctrl1_rd};
        end else if (hit_oppoint) begin
            rdata_d = {24'h00_0000, oppoint_q};
        end else if (hit_status) begin
            rdata_d = {24'h00_0000, status_rd};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            interval_q <= INTERVAL_RESET;
            remote2_code_msb_q <= CTRL1_RESET[REMOTE2_CODE_MSB_BIT];
            remote2_oppoint_capture_en_q <= CTRL1_RESET[CAPTURE_EN_BIT];
            oppoint_q <= OPPOINT_RESET;
        end else begin
            interval_q <= interval_d;
            remote2_code_msb_q <= remote2_code_msb_d;
            remote2_oppoint_capture_en_q <= remote2_oppoint_capture_en_d;
            oppoint_q <= oppoint_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            if (bus_req && !we_i) begin
                rdata_q <= rdata_d;
            end
        end
    end

    always_comb begin
        tick_cnt_d = tick_cnt_q + 25'h000_0001;
        if (tick_cnt_q >= TICK_W'(MON_CLKS - 1)) begin
            tick_cnt_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= (tick_cnt_q >= TICK_W'(MON_CLKS - 1));
        end
    end

    // alarm pin is asynchronous; only the second and third stages are looked at, never the first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_meta_q <= 1'b0;
            alarm_sync_q <= 1'b0;
            alarm_prev_q <= 1'b0;
        end else begin
            alarm_meta_q <= thermal_alarm_pin_i;
            alarm_sync_q <= alarm_meta_q;
            alarm_prev_q <= alarm_sync_q;
        end
    end

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        step_interval_timer u_timer (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick_q),
            .restart_i(step_done_i[ch]),
            .code_i(ch_code[ch]),
            .dec_ok_o(dec_ok[ch]),
            .inc_ok_o(inc_ok[ch])
        );
    end

    assign dat_o = rdata_q;
    assign ack_o = ack_q;
    assign dec_allow_o = dec_ok;
    assign inc_allow_o = inc_ok;
    assign mon_tick_o = tick_q;
    assign local_interval_code_o = local_code;
    assign remote1_interval_code_o = remote1_code;
    assign remote2_interval_code_o = remote2_code;
    assign remote2_oppoint_o = oppoint_q;

endmodule : dyn_thresh_interval

// File: sim/dyn_thresh_interval_chk.sv
`timescale 1ns/10ps
module dyn_thresh_interval_chk
    import dyn_thresh_pkg::*;
#(
    parameter int MON_CLKS = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // loop
    input wire logic [2:0] step_done_i,
    input wire logic [2:0] dec_allow_o,
    input wire logic [2:0] inc_allow_o,
    input wire logic [2:0] local_interval_code_o,
    input wire logic [2:0] remote1_interval_code_o,
    input wire logic [2:0] remote2_interval_code_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic [7:0] idx = adr_i[9:2];
    wire logic take = cyc_i && stb_i && !ack_o;
    wire logic wr = take && we_i && sel_i[0];
    sequence s_take; take; endsequence
    sequence s_ack_once; ack_o ##1 !ack_o; endsequence
    property p_ack; s_take |=> s_ack_once; endproperty
    a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
    property p_r1; wr && idx == REG_INTERVAL_IDX |=> remote1_interval_code_o == $past(dat_i[2:0]);
    endproperty
    a_r1: assert property (p_r1) else $error("remote1 code not updated");
    property p_loc; wr && idx == REG_INTERVAL_IDX |=> local_interval_code_o == $past(dat_i[5:3]);
    endproperty
    a_loc: assert property (p_loc) else $error("local code not updated");
    property p_r2; wr && idx == REG_INTERVAL_IDX |=>
        remote2_interval_code_o[1:0] == $past(dat_i[7:6]);
    endproperty
    a_r2: assert property (p_r2) else $error("remote2 low bits not updated");
    property p_r2_msb; wr && idx == REG_CTRL1_IDX |=>
        remote2_interval_code_o[2] == $past(dat_i[0]);
    endproperty
    a_r2_msb: assert property (p_r2_msb) else $error("remote2 msb not updated");
    property p_rst;
        disable iff (1'b0) rst_i |=> {local_interval_code_o, remote1_interval_code_o,
            remote2_interval_code_o, dec_allow_o, inc_allow_o, ack_o} == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    property p_step; |step_done_i |=> ((dec_allow_o | inc_allow_o) & $past(step_done_i)) == 0;
    endproperty
    a_step: assert property (p_step) else $error("allow survived a step");
    // increase waits are never shorter than decrease waits
    property p_inc_dec; (inc_allow_o & ~dec_allow_o) == 0; endproperty
    a_inc_dec: assert property (p_inc_dec) else $error("increase allowed before decrease");
    property p_stat; take && !we_i && idx == REG_STATUS_IDX |=>
        dat_o[5:0] == {$past(inc_allow_o), $past(dec_allow_o)}; endproperty
    a_stat: assert property (p_stat) else $error("status read mismatch");
endmodule : dyn_thresh_interval_chk
bind dyn_thresh_interval dyn_thresh_interval_chk #(.MON_CLKS(MON_CLKS)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .step_done_i(step_done_i),
    .dec_allow_o(dec_allow_o), .inc_allow_o(inc_allow_o),
    .local_interval_code_o(local_interval_code_o),
    .remote1_interval_code_o(remote1_interval_code_o),
    .remote2_interval_code_o(remote2_interval_code_o));

// File: sim/dyn_thresh_interval_tb_top.sv
`timescale 1ns/10ps
module dyn_thresh_interval_tb_top;
    import dyn_thresh_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, alarm = 0, ack, tick;
    logic [9:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] wdat = '0, rdat;
    logic [2:0] step = '0, dec, inc, c_loc, c_r1, c_r2;
    logic [7:0] temp = '0, opp, rd;
    int err_count = 0, cmp_count = 0, ticks;
    int dt[3], it[3];
    dyn_thresh_interval #(.MON_CLKS(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .step_done_i(step), .dec_allow_o(dec), .inc_allow_o(inc),
        .mon_tick_o(tick), .local_interval_code_o(c_loc), .remote1_interval_code_o(c_r1),
        .remote2_interval_code_o(c_r2), .thermal_alarm_pin_i(alarm), .remote2_temp_i(temp),
        .remote2_oppoint_o(opp));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= {3'b000, s};
        wdat <= {24'h00_0000, d};
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic finish_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, REG_INTERVAL_IDX, 8'h00, 1);
        check("interval reset", rd, INTERVAL_RESET);
        wb(1, REG_INTERVAL_IDX, 8'hff, 0);
        wb(0, REG_INTERVAL_IDX, 8'h00, 1);
        check("masked write", rd, INTERVAL_RESET);
        wb(1, 8'h3f, 8'ha5, 1);
        wb(0, 8'h3f, 8'h00, 1);
        check("unmapped", rd, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wb(1, REG_INTERVAL_IDX, {c[1:0], c[2:0], c[2:0]}, 1);
            wb(1, REG_CTRL1_IDX, {7'h00, c[2]}, 1);
            check("codes", {c_r2, c_loc, c_r1}, {c[2:0], c[2:0], c[2:0]});
            wb(0, REG_INTERVAL_IDX, 8'h00, 1);
            check("interval readback", rd, {c[1:0], c[2:0], c[2:0]});
            step <= 3'b111;
            @(posedge clk_i);
            step <= 3'b000;
            ticks = 0;
            dt = '{0, 0, 0};
            it = '{0, 0, 0};
            repeat (6000) begin
                @(posedge clk_i);
                if (tick === 1'b1) ticks++;
                for (int ch = 0; ch < 3; ch++) begin
                    if (dec[ch] === 1'b1 && dt[ch] == 0) dt[ch] = ticks;
                    if (inc[ch] === 1'b1 && it[ch] == 0) it[ch] = ticks;
                end
                if (it[0] != 0 && it[1] != 0 && it[2] != 0) break;
            end
            for (int ch = 0; ch < 3; ch++) begin
                check("decrease wait", dt[ch], 4 << c);
                check("increase wait", it[ch], (c > 5) ? 512 : 16 << c);
            end
        end
        wb(1, REG_STATUS_IDX, 8'h00, 1);
        wb(0, REG_STATUS_IDX, 8'h00, 1);
        check("status", rd, 8'h3f);
        // restart only the local channel; the other two keep their permissions
        step <= 3'b001;
        @(posedge clk_i);
        step <= 3'b000;
        wb(0, REG_STATUS_IDX, 8'h00, 1);
        check("status one restart", rd, 8'h36);
        wb(1, REG_OPPOINT_R2_IDX, 8'hc3, 1);
        wb(0, REG_OPPOINT_R2_IDX, 8'h00, 1);
        check("oppoint write", rd, 8'hc3);
        temp <= 8'h5a;
        wb(1, REG_CTRL1_IDX, 8'h10, 1);
        wb(0, REG_CTRL1_IDX, 8'h00, 1);
        check("capture enable readback", rd, 8'h10);
        alarm <= 1'b1;
        repeat (8) @(posedge clk_i);
        check("capture on", opp, 8'h5a);
        alarm <= 1'b0;
        wb(1, REG_CTRL1_IDX, 8'h00, 1);
        temp <= 8'h33;
        alarm <= 1'b1;
        repeat (8) @(posedge clk_i);
        wb(0, REG_OPPOINT_R2_IDX, 8'h00, 1);
        check("capture off", rd, 8'h5a);
        finish_test();
    end
endmodule : dyn_thresh_interval_tb_top
